// >>> sqrr_read_path.sv
// serial register read slave: opcode, address, dummy and data shifting
`timescale 1ns/1ps
module sqrr_read_path (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // serial pins from the host
    input  wire logic        chip_select_n,
    input  wire logic        sclk,
    input  wire logic [3:0]  sio_lanes_in,
    // serial pins to the host, enable low while driving
    output logic      [3:0]  sio_lanes_out,
    output logic      [3:0]  sio_lanes_oe_n,
    // register file side
    output logic      [11:0] reg_dw_addr,
    input  wire logic [31:0] reg_rd_data,
    output logic             reg_capture,
    output logic             reg_read_ind,
    output logic             reg_defer,
    // mode status
    output logic             four_lane_mode
);
    sqrr_pkg::sqrr_pins_t pins_in, pins_s;
    logic                 sclk_q_r, cs_q_r;
    logic                 sclk_rise, sclk_fall, cs_rise;

    sqrr_pkg::sqrr_state_t st_r, st_nxt;
    sqrr_pkg::sqrr_cmd_t   cmd_r, cmd_nxt;
    logic [5:0]  cnt_r, cnt_nxt;
    logic [7:0]  op_r, op_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [31:0] shift_r, shift_nxt;
    logic        quad_r, quad_nxt;
    logic        load_r, load_nxt;
    logic        first_r, first_nxt;
    logic [3:0]  out_r, out_nxt;
    logic [3:0]  oe_n_r, oe_n_nxt;
    logic        cap_r, cap_nxt;
    logic        ind_r, ind_nxt;
    logic        defer_r, defer_nxt;

    // every pin crosses two flops before use
    assign pins_in = '{cs_n: chip_select_n, sclk: sclk, sio: sio_lanes_in};

    sqrr_pin_sync #(
        .WIDTH   (sqrr_pkg::PIN_W),
        .RST_VAL (sqrr_pkg::PIN_RST)
    ) u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .pin_in   (pins_in),
        .pin_sync (pins_s)
    );

    // edge detection on the synchronised copies
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sclk_q_r <= 1'b0;
            cs_q_r   <= 1'b1;
        end else begin
            sclk_q_r <= pins_s.sclk;
            cs_q_r   <= pins_s.cs_n;
        end
    end

    assign sclk_rise = pins_s.sclk & ~sclk_q_r;
    assign sclk_fall = ~pins_s.sclk & sclk_q_r;
    assign cs_rise   = pins_s.cs_n & ~cs_q_r;

    // shift one beat of 1, 2 or 4 lanes into a header register
    function automatic logic [15:0] shift_in(input logic [15:0] v, input logic [1:0] lg,
                                             input logic [3:0] io);
        case (lg)
            sqrr_pkg::LG_TWO:  return {v[13:0], io[1:0]};
            sqrr_pkg::LG_FOUR: return {v[11:0], io};
            default:           return {v[14:0], io[0]};
        endcase
    endfunction

    // sequencer next state
    always_comb begin
        sqrr_pkg::sqrr_cmd_t dc;
        logic [15:0]         sh;
        dc        = sqrr_pkg::decode(op_r, quad_r);
        sh        = '0;
        st_nxt    = st_r;
        cmd_nxt   = cmd_r;
        cnt_nxt   = cnt_r;
        op_nxt    = op_r;
        addr_nxt  = addr_r;
        shift_nxt = shift_r;
        quad_nxt  = quad_r;
        load_nxt  = load_r;
        first_nxt = first_r;
        out_nxt   = out_r;
        oe_n_nxt  = oe_n_r;
        cap_nxt   = 1'b0;
        ind_nxt   = 1'b0;
        defer_nxt = defer_r;
        if (cs_rise) begin
            // end of frame: release lanes, drop partial header
            st_nxt    = sqrr_pkg::ST_IDLE;        // RL20 RL21
            oe_n_nxt  = sqrr_pkg::OE_N_OFF;       // RL10 RL18
            load_nxt  = 1'b0;
            first_nxt = 1'b0;
            defer_nxt = 1'b0;
        end else begin
            case (st_r)
                sqrr_pkg::ST_WAIT: begin
                    st_nxt = sqrr_pkg::ST_WAIT;   // RL20
                end
                sqrr_pkg::ST_IDLE: begin
                    if (!pins_s.cs_n) begin
                        st_nxt  = sqrr_pkg::ST_CMD; // RL6
                        cnt_nxt = sqrr_pkg::beats_m1(sqrr_pkg::OPC_BITS,
                                                     quad_r ? sqrr_pkg::LG_FOUR : sqrr_pkg::LG_ONE);
                    end
                end
                sqrr_pkg::ST_CMD: begin
                    if (sclk_rise) begin
                        sh     = shift_in({8'h00, op_r}, quad_r ? sqrr_pkg::LG_FOUR : sqrr_pkg::LG_ONE,
                                          pins_s.sio);
                        op_nxt = sh[7:0];
                        if (cnt_r == 6'h00) begin
                            dc      = sqrr_pkg::decode(sh[7:0], quad_r);
                            cmd_nxt = dc;
                            st_nxt  = sqrr_pkg::ST_IGNORE; // RL22
                            if (sh[7:0] == sqrr_pkg::OP_LEAVE_FOUR) begin
                                quad_nxt = 1'b0;          // RL19
                            end else if (sh[7:0] == sqrr_pkg::OP_ENTER_FOUR && !quad_r) begin
                                quad_nxt = 1'b1;          // RL19
                            end else if (dc.valid) begin
                                st_nxt  = sqrr_pkg::ST_ADDR; // RL7 RL11 RL12 RL13 RL14 RL15
                                cnt_nxt = sqrr_pkg::beats_m1(sqrr_pkg::ADDR_BITS, dc.addr_lg);
                            end
                        end else begin
                            cnt_nxt = cnt_r - 6'h01;
                        end
                    end
                end
                sqrr_pkg::ST_ADDR: begin
                    if (sclk_rise) begin
                        addr_nxt = shift_in(addr_r, cmd_r.addr_lg, pins_s.sio); // RL6
                        if (cnt_r != 6'h00) begin
                            cnt_nxt = cnt_r - 6'h01;
                        end else if (cmd_r.dummy_bytes == sqrr_pkg::DUMMY_NONE) begin
                            st_nxt   = sqrr_pkg::ST_DATA; // RL7 RL9
                            load_nxt = 1'b1;
                        end else begin
                            st_nxt  = sqrr_pkg::ST_DUMMY;
                            cnt_nxt = sqrr_pkg::beats_m1(int'(cmd_r.dummy_bytes) * sqrr_pkg::BYTE_BITS,
                                                         cmd_r.addr_lg); // RL11 RL12 RL13 RL15
                        end
                    end
                end
                sqrr_pkg::ST_DUMMY: begin
                    if (sclk_rise) begin
                        if (cnt_r == 6'h00) begin
                            st_nxt   = sqrr_pkg::ST_DATA;
                            load_nxt = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r - 6'h01;
                        end
                    end
                end
                sqrr_pkg::ST_DATA: begin
                    if (load_r) begin
                        // snapshot, byte 0 moved to the top so it leaves first
                        shift_nxt = {<<8{reg_rd_data}};  // RL3
                        cap_nxt   = 1'b1;                // RL3
                        defer_nxt = 1'b1;                // RL5
                        load_nxt  = 1'b0;
                        first_nxt = 1'b1;
                        cnt_nxt   = sqrr_pkg::beats_m1(sqrr_pkg::WORD_BITS, cmd_r.data_lg);
                    end else if (sclk_fall) begin
                        // drive on falling edges, msb of each group first
                        case (cmd_r.data_lg)
                            sqrr_pkg::LG_TWO: begin
                                out_nxt   = {2'b00, shift_r[31:30]};     // RL13 RL15
                                oe_n_nxt  = sqrr_pkg::OE_N_TWO;
                                shift_nxt = {shift_r[29:0], 2'b00};
                            end
                            sqrr_pkg::LG_FOUR: begin
                                out_nxt   = shift_r[31:28];              // RL12 RL14
                                oe_n_nxt  = sqrr_pkg::OE_N_FOUR;
                                shift_nxt = {shift_r[27:0], 4'h0};
                            end
                            default: begin
                                out_nxt   = {2'b00, shift_r[31], 1'b0};  // RL9 RL11
                                oe_n_nxt  = sqrr_pkg::OE_N_ONE;
                                shift_nxt = {shift_r[30:0], 1'b0};
                            end
                        endcase
                        if (first_r) begin
                            // side effects commit now, even if select rises mid-word
                            ind_nxt   = 1'b1;  // RL4
                            defer_nxt = 1'b0;  // RL5
                            first_nxt = 1'b0;
                        end
                        if (cnt_r == 6'h00) begin
                            // word done: step the dword address unless fixed, and reload
                            load_nxt = 1'b1;   // RL1
                            case (addr_r[sqrr_pkg::AMODE_HI:sqrr_pkg::AMODE_LO])
                                sqrr_pkg::AMODE_INC: addr_nxt[sqrr_pkg::DW_HI:sqrr_pkg::DW_LO] =
                                    addr_r[sqrr_pkg::DW_HI:sqrr_pkg::DW_LO] + sqrr_pkg::DW_ONE; // RL2
                                sqrr_pkg::AMODE_DEC: addr_nxt[sqrr_pkg::DW_HI:sqrr_pkg::DW_LO] =
                                    addr_r[sqrr_pkg::DW_HI:sqrr_pkg::DW_LO] - sqrr_pkg::DW_ONE; // RL2
                                default:             addr_nxt = addr_r; // RL2
                            endcase
                        end else begin
                            cnt_nxt = cnt_r - 6'h01;
                        end
                    end
                end
                sqrr_pkg::ST_IGNORE: begin
                    st_nxt = sqrr_pkg::ST_IGNORE; // RL22
                end
                default: begin
                    st_nxt = sqrr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // sequencer registers; reset waits for a select rising edge in single-lane mode
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_r    <= sqrr_pkg::ST_WAIT;   // RL20
            cmd_r   <= '0;
            cnt_r   <= '0;
            op_r    <= '0;
            addr_r  <= '0;
            shift_r <= '0;
            quad_r  <= 1'b0;                // RL21
            load_r  <= 1'b0;
            first_r <= 1'b0;
            out_r   <= '0;
            oe_n_r  <= sqrr_pkg::OE_N_OFF;
            cap_r   <= 1'b0;
            ind_r   <= 1'b0;
            defer_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cmd_r   <= cmd_nxt;
            cnt_r   <= cnt_nxt;
            op_r    <= op_nxt;
            addr_r  <= addr_nxt;
            shift_r <= shift_nxt;
            quad_r  <= quad_nxt;
            load_r  <= load_nxt;
            first_r <= first_nxt;
            out_r   <= out_nxt;
            oe_n_r  <= oe_n_nxt;
            cap_r   <= cap_nxt;
            ind_r   <= ind_nxt;
            defer_r <= defer_nxt;
        end
    end

    // outputs come straight from flops
    assign sio_lanes_out  = out_r;
    assign sio_lanes_oe_n = oe_n_r;
    assign reg_dw_addr    = addr_r[sqrr_pkg::DW_HI:sqrr_pkg::DW_LO];
    assign reg_capture    = cap_r;
    assign reg_read_ind   = ind_r;
    assign reg_defer      = defer_r;
    assign four_lane_mode = quad_r;
endmodule

// >>> sqrr_pkg.sv
// constants, types and command decode for the serial quad register read path
// Function
// (RL1) reads continue word after word while clock toggles and chip select stays low
// (RL2) address bits 15:14 pick increment 01b, decrement 10b, else fixed dword
// (RL3) selected register is snapshotted at the start of every 32-bit word
// (RL4) read side effect fires when shifting starts, even if select rises early
// (RL5) live-bit events after the snapshot are held until the read indication
// (RL6) transaction: select low, 8-bit opcode, then two byte-address bytes
// (RL7) single-lane read 03h takes opcode and address on io0, no dummy
// (RL8) host keeps clock at or below 30 MHz for the plain read
// (RL9) plain read drives io1 on fall after last address rise, byte 0 msb first
// (RL10) select high ends the transaction and releases io1
// (RL11) high-speed read 0Bh single lane: opcode, address, one dummy byte, then data
// (RL12) four-lane high-speed read: three dummy bytes, nibble data from byte 0
// (RL13) dual-output read 3Bh: serial header, one dummy byte, two-bit data
// (RL14) quad-output read 6Bh: serial header, one dummy byte, nibble data
// (RL15) dual io read BBh: opcode serial, address and two dummies on two lanes
// (RL16) host issues only the high-speed read while in four-lane mode
// (RL17) host keeps clock at or below 80 MHz for fast, dual and quad reads
// (RL18) multi-lane reads release every driven lane when select rises
// (RL19) 38h enters four-lane mode from single lane, FFh leaves from either
// (RL20) after reset pins are ignored until a rising edge of select
// (RL21) reset gives single-lane mode; early select rise drops partial headers
// (RL22) unknown opcode: lanes stay released, no register access until select rises
package sqrr_pkg;

    // opcodes
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_HIGH_SPEED = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
    localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
    localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
    localparam logic [7:0] OP_ENTER_FOUR = 8'h38;
    localparam logic [7:0] OP_LEAVE_FOUR = 8'hFF;

    // lane widths as log2 of lane count
    localparam logic [1:0] LG_ONE  = 2'h0;
    localparam logic [1:0] LG_TWO  = 2'h1;
    localparam logic [1:0] LG_FOUR = 2'h2;

    // field sizes and positions
    localparam int         OPC_BITS  = 8;
    localparam int         ADDR_BITS = 16;
    localparam int         WORD_BITS = 32;
    localparam int         BYTE_BITS = 8;
    localparam int         AMODE_HI  = 15;
    localparam int         AMODE_LO  = 14;
    localparam int         DW_HI     = 13;
    localparam int         DW_LO     = 2;
    localparam int         DW_BITS   = 12;
    localparam logic [1:0] AMODE_INC = 2'h1;
    localparam logic [1:0] AMODE_DEC = 2'h2;
    localparam logic [11:0] DW_ONE   = 12'h001;

    // dummy byte counts
    localparam logic [2:0] DUMMY_NONE  = 3'h0;
    localparam logic [2:0] DUMMY_ONE   = 3'h1;
    localparam logic [2:0] DUMMY_TWO   = 3'h2;
    localparam logic [2:0] DUMMY_THREE = 3'h3;
    localparam logic [2:0] DUMMY_FOUR  = 3'h4;

    // output enables, active low, lane 1 alone for single lane
    localparam logic [3:0] OE_N_OFF  = 4'hF;
    localparam logic [3:0] OE_N_ONE  = 4'hD;
    localparam logic [3:0] OE_N_TWO  = 4'hC;
    localparam logic [3:0] OE_N_FOUR = 4'h0;

    // pin synchroniser layout; reset levels are select high, clock low,
    // matching the edge detectors so no false edge follows reset
    localparam int         PIN_W   = 6;
    localparam logic [5:0] PIN_RST = 6'h20;

    typedef enum logic [2:0] {
        ST_WAIT   = 3'b101,
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b011,
        ST_DUMMY  = 3'b010,
        ST_DATA   = 3'b110,
        ST_IGNORE = 3'b111
    } sqrr_state_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] addr_lg;
        logic [1:0] data_lg;
        logic [2:0] dummy_bytes;
    } sqrr_cmd_t;

    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] sio;
    } sqrr_pins_t;

    // beats minus one for a field of the given bits on 2**lg lanes
    function automatic logic [5:0] beats_m1(input int bits, input logic [1:0] lg);
        return 6'((bits >> lg) - 1);
    endfunction

    // read opcode decode; only the high-speed read exists in four-lane mode
    function automatic sqrr_cmd_t decode(input logic [7:0] op, input logic four);
        sqrr_cmd_t c;
        c = '{valid: 1'b0, addr_lg: LG_ONE, data_lg: LG_ONE, dummy_bytes: DUMMY_NONE};
        if (four) begin
            if (op == OP_HIGH_SPEED)
                c = '{valid: 1'b1, addr_lg: LG_FOUR, data_lg: LG_FOUR, dummy_bytes: DUMMY_THREE};
        end else begin
            case (op)
                OP_READ:       c = '{1'b1, LG_ONE, LG_ONE, DUMMY_NONE};
                OP_HIGH_SPEED: c = '{1'b1, LG_ONE, LG_ONE, DUMMY_ONE};
                OP_DUAL_OUT:   c = '{1'b1, LG_ONE, LG_TWO, DUMMY_ONE};
                OP_QUAD_OUT:   c = '{1'b1, LG_ONE, LG_FOUR, DUMMY_ONE};
                OP_DUAL_IO:    c = '{1'b1, LG_TWO, LG_TWO, DUMMY_TWO};
                OP_QUAD_IO:    c = '{1'b1, LG_FOUR, LG_FOUR, DUMMY_FOUR};
                default:       c = c;
            endcase
        end
        return c;
    endfunction

endpackage

// >>> sqrr_pin_sync.sv
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module sqrr_pin_sync #(
    parameter int                 WIDTH   = 6,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // pins in, synchronised copy out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta_r   <= RST_VAL;
            pin_sync <= RST_VAL;
        end else begin
            meta_r   <= pin_in;
            pin_sync <= meta_r;
        end
    end
endmodule

// >>> sqrr_read_path_asserts.sv
// concurrent checks on the read path ports
`timescale 1ns/1ps
module sqrr_read_path_asserts (
    // clock and reset
    input wire logic        mclk,
    input wire logic        resetn,
    // serial pins
    input wire logic        chip_select_n,
    input wire logic        sclk,
    input wire logic [3:0]  sio_lanes_in,
    input wire logic [3:0]  sio_lanes_out,
    input wire logic [3:0]  sio_lanes_oe_n,
    // register side and mode
    input wire logic [11:0] reg_dw_addr,
    input wire logic [31:0] reg_rd_data,
    input wire logic        reg_capture,
    input wire logic        reg_read_ind,
    input wire logic        reg_defer,
    input wire logic        four_lane_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // deselect must free every lane within the sync latency
    lane_release_a: assert property (chip_select_n [*5] |-> sio_lanes_oe_n == 4'hF)
        else $error("lanes still driven after deselect");
    enable_shape_a: assert property (sio_lanes_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
        else $error("illegal lane enable pattern");
    // a snapshot is followed by its read indication unless the frame ends
    snap_then_ind_a: assert property (reg_capture |-> ##[1:20] (reg_read_ind || chip_select_n))
        else $error("no read indication after snapshot");
    defer_open_a: assert property (reg_capture |=> reg_defer)
        else $error("defer not raised by snapshot");
    defer_close_a: assert property (reg_read_ind |=> !reg_defer)
        else $error("defer not dropped after read indication");
    ind_in_window_a: assert property (reg_read_ind |-> $past(reg_defer))
        else $error("read indication without a pending snapshot");
    // data lanes move only on falling clock edges
    out_hold_a: assert property ((sclk && !chip_select_n && sio_lanes_oe_n != 4'hF) [*2]
        |-> $stable(sio_lanes_out))
        else $error("data lanes moved while clock high");
    mode_reset_a: assert property (disable iff (1'b0) !resetn |=> !four_lane_mode)
        else $error("reset did not return to single lane");
    mode_in_frame_a: assert property ($changed(four_lane_mode) |-> !$past(chip_select_n, 4))
        else $error("mode changed outside a frame");
    deselect_quiet_a: assert property (chip_select_n [*6] |-> !reg_capture && !reg_read_ind)
        else $error("register access while deselected");
endmodule

bind sqrr_read_path sqrr_read_path_asserts sqrr_read_path_asserts_inst (.mclk(mclk), .resetn(resetn),
    .chip_select_n(chip_select_n), .sclk(sclk), .sio_lanes_in(sio_lanes_in), .sio_lanes_out(sio_lanes_out),
    .sio_lanes_oe_n(sio_lanes_oe_n), .reg_dw_addr(reg_dw_addr), .reg_rd_data(reg_rd_data),
    .reg_capture(reg_capture), .reg_read_ind(reg_read_ind), .reg_defer(reg_defer),
    .four_lane_mode(four_lane_mode));

// >>> sqrr_host_model.sv
// host side serial master: select, clock, header lanes and data capture
`timescale 1ns/1ps
module sqrr_host_model (
    // clock
    input  wire logic       mclk,
    // resolved lane levels
    input  wire logic [3:0] lanes,
    // host pins
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      drv
);
    logic [31:0] rx [4];
    // select starts low so the first frame after reset has no rising edge
    initial begin
        cs_n = 1'b0;
        sclk = 1'b0;
        drv = 4'h0;
    end
    // one frame; stop cuts it after that many clock beats, 0 runs it whole
    task automatic xfer(input logic [7:0] op, input int olg, input logic [15:0] a, input int alg,
                        input int dby, input int dlg, input int nw, input int stop);
        logic [47:0] hdr;
        logic [31:0] sh;
        int          ob, hb, n, w, k, m;
        hdr = {a, 32'hC3C3_C3C3};
        ob = 8 >> olg;
        hb = ob + ((16 + 8 * dby) >> alg);
        w = 32 >> dlg;
        n = hb + nw * w;
        sh = 32'h0;
        cs_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int b = 0; b < n && (stop == 0 || b < stop); b++) begin
            k = 1 << (b < ob ? olg : b < hb ? alg : dlg);
            m = (1 << k) - 1;
            sclk <= 1'b0;
            // header msb first; lanes not in use toggle so they never look held
            if (b < ob)
                drv <= (~drv & ~4'(m)) | 4'((op >> (8 - (b + 1) * k)) & m);
            else if (b < hb)
                drv <= (~drv & ~4'(m)) | 4'((hdr >> (48 - (b - ob + 1) * k)) & m);
            else
                drv <= ~drv;
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            // long high after the header leaves room for the snapshot
            repeat (b == hb - 1 ? 12 : 4) @(posedge mclk);
            if (b >= hb) begin
                sh = (sh << k) | 32'(dlg == 0 ? {3'b0, lanes[1]} : lanes & 4'(m));
                if ((b - hb) % w == w - 1)
                    rx[(b - hb) / w] = sh;
            end
        end
        cs_n <= 1'b1;
        repeat (2) @(posedge mclk);
        sclk <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// >>> serial_quad_register_read_path_tb_top.sv
// self-checking bench for the serial register read path
`timescale 1ns/1ps
module serial_quad_register_read_path_tb_top;
    logic        mclk;
    logic        resetn;
    logic        cs_n;
    logic        sclk;
    logic [3:0]  drv;
    logic [3:0]  lanes;
    logic [3:0]  sio_out;
    logic [3:0]  oe_n;
    logic [11:0] dw;
    logic [31:0] rd;
    logic        cap;
    logic        ind;
    logic        defer;
    logic        four;
    logic [3:0]  oe_seen;
    int          errors;
    int          compares;
    int          caps;
    int          inds;
    // register contents derived from the dword address
    function automatic logic [31:0] regval(input logic [11:0] a);
        return {4'h9, a, 4'h6, ~a};
    endfunction
    // byte 0 first on the wire
    function automatic logic [31:0] es(input logic [11:0] a);
        logic [31:0] v;
        v = regval(a);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    // device wins on the lanes it enables
    assign lanes = (sio_out & ~oe_n) | (drv & oe_n);
    assign rd = regval(dw);
    sqrr_read_path sqrr_read_path_inst (.mclk(mclk), .resetn(resetn), .chip_select_n(cs_n), .sclk(sclk),
        .sio_lanes_in(lanes), .sio_lanes_out(sio_out), .sio_lanes_oe_n(oe_n), .reg_dw_addr(dw),
        .reg_rd_data(rd), .reg_capture(cap), .reg_read_ind(ind), .reg_defer(defer), .four_lane_mode(four));
    sqrr_host_model sqrr_host_model_inst (.mclk(mclk), .lanes(lanes), .cs_n(cs_n), .sclk(sclk), .drv(drv));
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;
    // pulse counters and last driven enable pattern
    always @(posedge mclk) begin
        if (cap === 1'b1)
            caps++;
        if (ind === 1'b1)
            inds++;
        if (oe_n !== 4'hF)
            oe_seen = oe_n;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [7:0] op, input int olg, input logic [15:0] a, input int alg,
                       input int dby, input int dlg, input int nw, input int stop);
        caps = 0;
        inds = 0;
        oe_seen = 4'hF;
        sqrr_host_model_inst.xfer(op, olg, a, alg, dby, dlg, nw, stop);
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a frame before the first select rise is ignored
    task automatic t_first();
        run(8'h03, 0, 16'h4040, 0, 0, 0, 1, 0);
        chk(32'(caps), 32'h0);
        chk(32'(oe_seen), 32'hF);
    endtask
    // plain read, three words with increment
    task automatic t_plain();
        run(8'h03, 0, 16'h4040, 0, 0, 0, 3, 0);
        for (int j = 0; j < 3; j++) begin
            chk(sqrr_host_model_inst.rx[j], es(12'h010 + 12'(j)));
        end
        // the word after the last is snapshotted as well, but never shifted
        chk(32'(caps), 32'h4);
        chk(32'(inds), 32'h3);
        chk(32'(defer), 32'h0);
    endtask
    // every other read opcode, alternating decrement and fixed address
    task automatic t_table();
        logic [7:0] ops [5] = '{8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
        logic [3:0] oes [5] = '{4'hD, 4'hC, 4'h0, 4'hC, 4'h0};
        int         al [5] = '{0, 0, 0, 1, 2};
        int         db [5] = '{1, 1, 1, 2, 4};
        int         dl [5] = '{0, 1, 2, 1, 2};
        for (int i = 0; i < 5; i++) begin
            run(ops[i], 0, i[0] ? 16'h0208 : 16'h8100, al[i], db[i], dl[i], 2, 0);
            chk(32'(oe_seen), 32'(oes[i]));
            for (int j = 0; j < 2; j++) begin
                chk(sqrr_host_model_inst.rx[j], es(i[0] ? 12'h082 : 12'h040 - 12'(j)));
            end
        end
    endtask
    // four-lane entry, fast read, refused plain read, exit
    task automatic t_four();
        run(8'h38, 0, 16'h0, 0, -2, 0, 0, 0);
        chk(32'(four), 32'h1);
        run(8'h0B, 2, 16'h4010, 2, 3, 2, 2, 0);
        chk(32'(oe_seen), 32'h0);
        for (int j = 0; j < 2; j++) begin
            chk(sqrr_host_model_inst.rx[j], es(12'h004 + 12'(j)));
        end
        run(8'h03, 2, 16'h4010, 2, 0, 0, 1, 0);
        chk(32'(caps), 32'h0);
        chk(32'(oe_seen), 32'hF);
        run(8'hFF, 2, 16'h0, 0, -2, 0, 0, 0);
        chk(32'(four), 32'h0);
    endtask
    // header cut short, word cut short, unknown opcode
    task automatic t_abort();
        run(8'h03, 0, 16'h0208, 0, 0, 0, 1, 12);
        chk(32'(caps), 32'h0);
        run(8'h03, 0, 16'h0208, 0, 0, 0, 1, 29);
        chk(32'(inds), 32'h1);
        chk(32'(oe_n), 32'hF);
        run(8'h5A, 0, 16'h4040, 0, 0, 0, 1, 0);
        chk(32'(caps + inds), 32'h0);
        chk(32'(oe_seen), 32'hF);
    endtask
    initial begin
        resetn = 1'b0;
        errors = 0;
        compares = 0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_first();
        t_plain();
        t_table();
        t_four();
        t_abort();
        give_verdict();
    end
    // whole run needs well under this many cycles
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        give_verdict();
    end
endmodule
